// *** rtl/ctrl_port_reset_powerdown.sv ***
// Serial control target, soft reset and power-down control
`timescale 1ns/100ps
module ctrl_port_reset_powerdown #(
    parameter int NvWaitCycles = ctrl_port_pkg::NV_WAIT_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] port_sel_hi,
    input wire logic [1:0] port_sel_lo,
    input wire logic nvSelect,
    input wire logic chip_sleep_n,
    input wire logic chargePumpEvent,
    input wire logic distClkLow,
    output logic spiEnable,
    output logic i2cEnable,
    output logic [6:0] i2cAddress,
    output logic pllOff,
    output logic vcoOff,
    output logic [3:0] dividerOff,
    output logic [11:0] driverOff,
    output logic cmosTristate,
    output logic lvdsHiZ,
    output logic distPowerDown,
    output logic outputsStatic,
    output logic softResetActive,
    output logic loadDefaults,
    output logic nvReloadReq,
    output logic alignReq
);

    // Synchronised pins
    logic [9:0] rawIn;
    logic [9:0] syncIn;
    logic sclS, sdaS, nvSelS, sleepReqS, cpS, clkLowS;
    logic [1:0] selHiS, selLoS;
    logic sclQ, sdaQ, cpQ;
    logic sclRise, sclFall, startCond, stopCond, cpRise;

    // Strap capture
    logic [1:0] strapCnt;
    logic strapTaken;

    // Serial target
    ctrl_port_pkg::tgt_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shiftIn;
    logic [7:0] txShift;
    logic [15:0] regAddr;
    logic sdaDrive;
    logic wrStrobe;
    logic [15:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] readData;
    logic [2:0] txIdx;

    // Reset control
    logic [7:0] portCfg;
    logic softPending;
    logic nvBit;
    logic defPulse;
    logic nvPulse;
    logic alignPulse;
    logic [ctrl_port_pkg::NV_WAIT_BITS-1:0] nvWaitCnt;

    // Control registers
    ctrl_port_pkg::pll_pd_mode_t pllMode;
    logic distPd;
    logic [11:0] outPd;
    logic [3:0] chanPd;
    logic pllPd;
    logic sleepGate;
    logic sleepAlign;
    logic [11:0] next_driverOff;

    // Output-register address decode
    function automatic logic isOutAddr(input logic [15:0] a);
        return (a >= ctrl_port_pkg::ADDR_OUT_FIRST) &&
               (a <= ctrl_port_pkg::ADDR_OUT_LAST);
    endfunction

    // Channel register decode, one-hot
    function automatic logic [3:0] chanSel(input logic [15:0] a);
        return {a == ctrl_port_pkg::ADDR_CHAN3,
                a == ctrl_port_pkg::ADDR_CHAN2,
                a == ctrl_port_pkg::ADDR_CHAN1,
                a == ctrl_port_pkg::ADDR_CHAN0};
    endfunction

    // Three-level strap to its digit
    function automatic logic [2:0] levelVal(input logic [1:0] p);
        unique case (p)
            ctrl_port_pkg::LVL_LOW: return 3'h0;
            ctrl_port_pkg::LVL_OPEN: return 3'h1;
            default: return 3'h2;
        endcase
    endfunction

    // Every pin passes two flops; sampling at 250 MHz covers both bus rates
    // Bus lines cross inverted, so the flops' reset level is the idle bus
    assign rawIn = 10'h300 ^ {sclIn, sdaIn, port_sel_hi, port_sel_lo,
                   nvSelect, ~chip_sleep_n, chargePumpEvent,
                   distClkLow};
    sync_stage #(
        .WIDTH(ctrl_port_pkg::SYNC_WIDTH)
    ) u_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .d(rawIn),
        .q(syncIn)
    );
    assign {sclS, sdaS, selHiS, selLoS, nvSelS, sleepReqS, cpS,
            clkLowS} = syncIn ^ 10'h300;

    // Edge history of synchronised lines
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
            cpQ <= 1'b0;
        end else begin
            sclQ <= sclS;
            sdaQ <= sdaS;
            cpQ <= cpS;
        end
    end

    assign sclRise = sclS & ~sclQ;
    assign sclFall = ~sclS & sclQ;
    assign startCond = sclS & sclQ & sdaQ & ~sdaS;
    assign stopCond = sclS & sclQ & ~sdaQ & sdaS;
    assign cpRise = cpS & ~cpQ;

    // Straps taken once, after the synchronisers have settled
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapCnt <= 2'h0;
            strapTaken <= 1'b0;
            spiEnable <= 1'b0;
            i2cEnable <= 1'b0;
            i2cAddress <= 7'h00;
        end else if (!strapTaken) begin
            if (strapCnt == 2'(ctrl_port_pkg::STRAP_SETTLE)) begin
                strapTaken <= 1'b1;
                spiEnable <= (selHiS == ctrl_port_pkg::LVL_HIGH) &&
                             (selLoS == ctrl_port_pkg::LVL_HIGH);
                i2cEnable <= !((selHiS == ctrl_port_pkg::LVL_HIGH) &&
                               (selLoS == ctrl_port_pkg::LVL_HIGH));
                i2cAddress <= {ctrl_port_pkg::I2C_ADDR_FIXED,
                               3'(levelVal(selHiS) * 3'h3 +
                                  levelVal(selLoS))};
            end else begin
                strapCnt <= strapCnt + 2'h1;
            end
        end
    end

    assign txIdx = 3'h7 - bitCnt[2:0];

    // Byte engine: bits in on SCL rise, SDA changes only on SCL fall
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ctrl_port_pkg::ST_IDLE;
            bitCnt <= 4'h0;
            shiftIn <= 8'h00;
            txShift <= 8'h00;
            regAddr <= 16'h0000;
            sdaDrive <= 1'b0;
            wrStrobe <= 1'b0;
            wrAddr <= 16'h0000;
            wrData <= 8'h00;
        end else begin
            wrStrobe <= 1'b0;
            if (!i2cEnable) begin
                state <= ctrl_port_pkg::ST_IDLE;
                sdaDrive <= 1'b0;
            end else if (startCond || stopCond) begin
                // Partial byte is dropped by clearing the count
                state <= startCond ? ctrl_port_pkg::ST_ADDR :
                                     ctrl_port_pkg::ST_IDLE;
                bitCnt <= 4'h0;
                sdaDrive <= 1'b0;
            end else if (state != ctrl_port_pkg::ST_IDLE &&
                         state != ctrl_port_pkg::ST_IGNORE) begin
                if (sclRise) begin
                    if (bitCnt < 4'h8) begin
                        shiftIn <= {shiftIn[6:0], sdaS};
                        bitCnt <= bitCnt + 4'h1;
                    end else begin
                        bitCnt <= 4'h9;
                        // Controller left SDA high: reading ends here
                        if (state == ctrl_port_pkg::ST_READ && sdaS) begin
                            state <= ctrl_port_pkg::ST_IGNORE;
                        end
                    end
                end else if (sclFall) begin
                    if (bitCnt == 4'h8) begin
                        unique case (state)
                            ctrl_port_pkg::ST_ADDR: begin
                                if (shiftIn[7:1] == i2cAddress) begin
                                    sdaDrive <= 1'b1;
                                    state <= shiftIn[0] ?
                                        ctrl_port_pkg::ST_READ :
                                        ctrl_port_pkg::ST_REGHI;
                                end else begin
                                    state <= ctrl_port_pkg::ST_IGNORE;
                                end
                            end
                            ctrl_port_pkg::ST_REGHI: begin
                                regAddr[15:8] <= shiftIn;
                                sdaDrive <= 1'b1;
                                state <= ctrl_port_pkg::ST_REGLO;
                            end
                            ctrl_port_pkg::ST_REGLO: begin
                                regAddr[7:0] <= shiftIn;
                                sdaDrive <= 1'b1;
                                state <= ctrl_port_pkg::ST_WDATA;
                            end
                            ctrl_port_pkg::ST_WDATA: begin
                                wrStrobe <= 1'b1;
                                wrAddr <= regAddr;
                                wrData <= shiftIn;
                                regAddr <= regAddr + 16'h0001;
                                sdaDrive <= 1'b1;
                            end
                            ctrl_port_pkg::ST_READ: begin
                                sdaDrive <= 1'b0;
                                regAddr <= regAddr + 16'h0001;
                            end
                            ctrl_port_pkg::ST_IDLE,
                            ctrl_port_pkg::ST_IGNORE: begin
                                sdaDrive <= 1'b0;
                            end
                        endcase
                    end else if (bitCnt == 4'h9) begin
                        bitCnt <= 4'h0;
                        if (state == ctrl_port_pkg::ST_READ) begin
                            txShift <= readData;
                            sdaDrive <= ~readData[7];
                        end else begin
                            sdaDrive <= 1'b0;
                        end
                    end else if (state == ctrl_port_pkg::ST_READ &&
                                 bitCnt != 4'h0) begin
                        sdaDrive <= ~txShift[txIdx];
                    end
                end
            end else begin
                sdaDrive <= 1'b0;
            end
        end
    end

    // Open-drain data pin; SCL is input only
    assign sdaOut = 1'b0;
    assign sdaOe = sdaDrive;

    // Read-back of the registers held here; others read zero
    always_comb begin
        readData = 8'h00;
        if (regAddr == ctrl_port_pkg::ADDR_PORT_CFG) begin
            readData = portCfg;
        end else if (regAddr == ctrl_port_pkg::ADDR_PLL_PD) begin
            readData = {6'h00, pllMode};
        end else if (isOutAddr(regAddr)) begin
            readData = {7'h00, outPd[regAddr[3:0]]};
        end else if (chanSel(regAddr) != 4'h0) begin
            readData = {5'h00, |(chanSel(regAddr) & chanPd), 2'h0};
        end else if (regAddr == ctrl_port_pkg::ADDR_DIST) begin
            readData = {6'h00, distPd, 1'b0};
        end else if (regAddr == ctrl_port_pkg::ADDR_NV_CTRL) begin
            readData = {6'h00, nvBit, 1'b0};
        end
    end

    // Soft reset and reload bits; clearing waits for one more SCL rise
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            portCfg <= ctrl_port_pkg::PORT_CFG_RESET;
            softPending <= 1'b0;
            nvBit <= 1'b0;
            defPulse <= 1'b0;
            nvPulse <= 1'b0;
            alignPulse <= 1'b0;
        end else begin
            defPulse <= 1'b0;
            nvPulse <= 1'b0;
            alignPulse <= 1'b0;
            if (wrStrobe && wrAddr == ctrl_port_pkg::ADDR_PORT_CFG) begin
                portCfg <= wrData;
                if (wrData[ctrl_port_pkg::PORT_CFG_RST_LO_BIT] &&
                    wrData[ctrl_port_pkg::PORT_CFG_RST_HI_BIT]) begin
                    softPending <= 1'b1;
                end
            end else if (softPending && sclRise) begin
                portCfg[ctrl_port_pkg::PORT_CFG_RST_LO_BIT] <= 1'b0;
                portCfg[ctrl_port_pkg::PORT_CFG_RST_HI_BIT] <= 1'b0;
                softPending <= 1'b0;
                defPulse <= ~nvSelS;
                nvPulse <= nvSelS;
                alignPulse <= 1'b1;
            end
            if (wrStrobe && wrAddr == ctrl_port_pkg::ADDR_NV_CTRL) begin
                // Without the select pin the bit never sets
                nvBit <= wrData[ctrl_port_pkg::NV_LOAD_BIT] & nvSelS;
            end else if (nvBit && sclRise) begin
                nvBit <= 1'b0;
                nvPulse <= 1'b1;
            end
        end
    end

    // Reload settle time before outputs may toggle again
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nvWaitCnt <= '0;
        end else if (nvPulse) begin
            nvWaitCnt <= ctrl_port_pkg::NV_WAIT_BITS'(NvWaitCycles);
        end else if (nvWaitCnt != '0) begin
            nvWaitCnt <= nvWaitCnt - 1'b1;
        end
    end

    // Control registers; writes land even while asleep
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pllMode <= ctrl_port_pkg::pll_pd_mode_t'(
                ctrl_port_pkg::PLL_PD_RESET);
            distPd <= ctrl_port_pkg::DIST_PD_RESET;
            outPd <= ctrl_port_pkg::OUT_PD_RESET;
            chanPd <= ctrl_port_pkg::CHAN_PD_RESET;
        end else if (defPulse) begin
            pllMode <= ctrl_port_pkg::pll_pd_mode_t'(
                ctrl_port_pkg::PLL_PD_RESET);
            distPd <= ctrl_port_pkg::DIST_PD_RESET;
            outPd <= ctrl_port_pkg::OUT_PD_RESET;
            chanPd <= ctrl_port_pkg::CHAN_PD_RESET;
        end else if (wrStrobe) begin
            if (wrAddr == ctrl_port_pkg::ADDR_PLL_PD) begin
                pllMode <= ctrl_port_pkg::pll_pd_mode_t'(wrData[1:0]);
            end
            if (wrAddr == ctrl_port_pkg::ADDR_DIST) begin
                distPd <= wrData[ctrl_port_pkg::DIST_PD_BIT];
            end
            if (isOutAddr(wrAddr)) begin
                outPd[wrAddr[3:0]] <= wrData[ctrl_port_pkg::OUT_PD_BIT];
            end
            for (int c = 0; c < ctrl_port_pkg::NUM_CHANNELS; c++) begin
                if (chanSel(wrAddr)[c]) begin
                    chanPd[c] <= wrData[ctrl_port_pkg::CHAN_PD_BIT];
                end
            end
        end
    end

    // PLL power-down; the synchronous mode waits for the charge pump
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pllPd <= 1'b0;
        end else begin
            unique case (pllMode)
                ctrl_port_pkg::PLL_PD_ASYNC: pllPd <= 1'b1;
                ctrl_port_pkg::PLL_PD_SYNC: begin
                    if (cpRise) begin
                        pllPd <= 1'b1;
                    end
                end
                ctrl_port_pkg::PLL_RUN,
                ctrl_port_pkg::PLL_RUN_ALT: pllPd <= 1'b0;
            endcase
        end
    end

    // Sleep gate moves only while the output clock is low, so no runts
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sleepGate <= 1'b0;
            sleepAlign <= 1'b0;
        end else begin
            sleepAlign <= 1'b0;
            if (clkLowS && sleepGate != sleepReqS) begin
                sleepGate <= sleepReqS;
                sleepAlign <= ~sleepReqS;
            end
        end
    end

    // Driver off when itself, its channel, distribution or sleep says so
    generate
        for (genvar i = 0; i < ctrl_port_pkg::NUM_OUTPUTS; i++) begin : g_drv
            assign next_driverOff[i] = outPd[i] | distPd | sleepGate |
                chanPd[i / ctrl_port_pkg::OUTS_PER_CHAN];
        end
    endgenerate

    // Registered outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pllOff <= 1'b0;
            vcoOff <= 1'b0;
            dividerOff <= 4'h0;
            driverOff <= 12'h000;
            cmosTristate <= 1'b0;
            lvdsHiZ <= 1'b0;
            distPowerDown <= 1'b0;
            outputsStatic <= 1'b0;
            softResetActive <= 1'b0;
            loadDefaults <= 1'b0;
            nvReloadReq <= 1'b0;
            alignReq <= 1'b0;
        end else begin
            pllOff <= pllPd | sleepGate;
            vcoOff <= sleepGate;
            dividerOff <= chanPd | {4{sleepGate}};
            driverOff <= next_driverOff;
            cmosTristate <= sleepGate;
            lvdsHiZ <= sleepGate;
            distPowerDown <= distPd;
            outputsStatic <= softPending | nvBit | defPulse | nvPulse |
                             (nvWaitCnt != '0);
            softResetActive <= softPending;
            loadDefaults <= defPulse;
            nvReloadReq <= nvPulse;
            alignReq <= alignPulse | sleepAlign;
        end
    end

endmodule

// *** rtl/ctrl_port_pkg.sv ***
// Constants and types for the control port, reset and power-down block
package ctrl_port_pkg;

    // Register addresses, 16-bit register space
    localparam logic [15:0] ADDR_PORT_CFG = 16'h0000;
    localparam logic [15:0] ADDR_PLL_PD = 16'h0010;
    localparam logic [15:0] ADDR_OUT_FIRST = 16'h00F0;
    localparam logic [15:0] ADDR_OUT_LAST = 16'h00FB;
    localparam logic [15:0] ADDR_CHAN0 = 16'h0192;
    localparam logic [15:0] ADDR_CHAN1 = 16'h0195;
    localparam logic [15:0] ADDR_CHAN2 = 16'h0198;
    localparam logic [15:0] ADDR_CHAN3 = 16'h019B;
    localparam logic [15:0] ADDR_DIST = 16'h0230;
    localparam logic [15:0] ADDR_NV_CTRL = 16'h0B02;

    // Field positions
    localparam int PORT_CFG_RST_LO_BIT = 2;
    localparam int PORT_CFG_RST_HI_BIT = 5;
    localparam int DIST_PD_BIT = 1;
    localparam int OUT_PD_BIT = 0;
    localparam int CHAN_PD_BIT = 2;
    localparam int NV_LOAD_BIT = 1;

    // Reset values
    localparam logic [7:0] PORT_CFG_RESET = 8'h00;
    localparam logic [1:0] PLL_PD_RESET = 2'h0;
    localparam logic [11:0] OUT_PD_RESET = 12'h000;
    localparam logic [3:0] CHAN_PD_RESET = 4'h0;
    localparam logic DIST_PD_RESET = 1'b0;

    // Sizes
    localparam int NUM_OUTPUTS = 12;
    localparam int NUM_CHANNELS = 4;
    localparam int OUTS_PER_CHAN = 3;
    localparam int SYNC_WIDTH = 10;

    // Target address upper bits, fixed
    localparam logic [3:0] I2C_ADDR_FIXED = 4'hB;

    // Timing
    localparam int SYS_CLK_NS = 4;
    localparam int NV_WAIT_NS = 20_000_000;
    localparam int NV_WAIT_CYC = NV_WAIT_NS / SYS_CLK_NS;
    localparam int NV_WAIT_BITS = 24;
    localparam int STRAP_SETTLE = 3;

    // Three-level strap pin as seen after the pad comparators
    typedef enum logic [1:0] {
        LVL_LOW = 2'b00,
        LVL_OPEN = 2'b01,
        LVL_HIGH = 2'b10
    } pin_level_t;

    // PLL power-down field
    typedef enum logic [1:0] {
        PLL_RUN = 2'b00,
        PLL_PD_ASYNC = 2'b01,
        PLL_RUN_ALT = 2'b10,
        PLL_PD_SYNC = 2'b11
    } pll_pd_mode_t;

    // Serial target states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_REGHI = 3'b010,
        ST_REGLO = 3'b011,
        ST_WDATA = 3'b100,
        ST_READ = 3'b101,
        ST_IGNORE = 3'b110
    } tgt_state_t;

endpackage

// *** rtl/sync_stage.sv ***
// Two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/100ps
module sync_stage #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// *** tb/ctrl_port_sva.sv ***
// Checker for the control port, reset and power-down block
`timescale 1ns/100ps
module ctrl_port_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sclIn,
    input wire logic sdaOe,
    input wire logic nvSelect,
    input wire logic distClkLow,
    input wire logic spiEnable,
    input wire logic i2cEnable,
    input wire logic vcoOff,
    input wire logic cmosTristate,
    input wire logic lvdsHiZ,
    input wire logic distPowerDown,
    input wire logic outputsStatic,
    input wire logic softResetActive,
    input wire logic loadDefaults,
    input wire logic nvReloadReq,
    input wire logic [1:0] port_sel_hi,
    input wire logic [6:0] i2cAddress,
    input wire logic [11:0] driverOff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Pad controls of sleep move together
    property p_sleep; cmosTristate |-> vcoOff && lvdsHiZ; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep");
    property p_spi; spiEnable |-> !i2cEnable && port_sel_hi[1]; endproperty
    a_spi: assert property (p_spi) else $error("spi");
    property p_adr; i2cEnable |-> i2cAddress[6:3] == 4'hB; endproperty
    a_adr: assert property (p_adr) else $error("address");
    property p_hold; softResetActive |-> outputsStatic; endproperty
    a_hold: assert property (p_hold) else $error("static");
    property p_def; loadDefaults |-> !nvSelect && !nvReloadReq; endproperty
    a_def: assert property (p_def) else $error("defaults");
    property p_nv; nvReloadReq |-> nvSelect; endproperty
    a_nv: assert property (p_nv) else $error("reload");
    property p_dist; distPowerDown |-> &driverOff; endproperty
    a_dist: assert property (p_dist) else $error("dist");
    // Target may only move SDA while the clock is low
    property p_sda; $changed(sdaOe) |-> !sclIn; endproperty
    a_sda: assert property (p_sda) else $error("sda");
    // Sleep pads move only after a low phase of the distribution clock
    property p_runt;
        $changed(cmosTristate) |-> $past(distClkLow, 4);
    endproperty
    a_runt: assert property (p_runt) else $error("runt");
    cover property (loadDefaults);
    cover property (nvReloadReq);
    cover property (cmosTristate);
endmodule

bind ctrl_port_reset_powerdown ctrl_port_sva chk (.sys_clk, .sys_rst,
    .sclIn, .sdaOe, .nvSelect, .distClkLow, .spiEnable, .i2cEnable, .vcoOff,
    .cmosTristate, .lvdsHiZ, .distPowerDown, .outputsStatic,
    .softResetActive, .loadDefaults, .nvReloadReq, .port_sel_hi,
    .i2cAddress, .driverOff);

// *** tb/i2c_host_model.sv ***
// Behavioural I2C controller driving the link from outside
`timescale 1ns/100ps
module i2c_host_model (
    output logic scl,
    output logic sdaDrv,
    input wire logic sdaWire
);
    // Quarter of the 32 ns link clock period
    localparam time Q = 8;
    // Idle bus rests released high
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // One bit per pulse, data moved only in the low phase
    task automatic bitx(input logic b, output logic r);
        sdaDrv = b;
        #Q scl = 1'b1;
        #Q r = sdaWire;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic start();
        sdaDrv = 1'b1;
        #Q scl = 1'b1;
        #Q sdaDrv = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sdaDrv = 1'b0;
        #Q scl = 1'b1;
        #Q sdaDrv = 1'b1;
        #Q;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the control port and power-down block
`timescale 1ns/100ps
module testbench;
    logic sys_clk, sys_rst, nvSelect, chip_sleep_n, chargePumpEvent, ack;
    logic sclIn, sdaDrv, sdaOe, spiEnable, i2cEnable, pllOff, vcoOff;
    logic cmosTristate, lvdsHiZ, distPowerDown, outputsStatic, alignReq;
    logic softResetActive, loadDefaults, nvReloadReq, distClkLow = 1'b1;
    logic [1:0] port_sel_hi, port_sel_lo;
    logic [3:0] dividerOff;
    logic [6:0] i2cAddress;
    logic [7:0] rdata;
    logic [11:0] driverOff;
    logic [31:0] seed = 32'h0000_2256;
    int fail_count = 0, comparisons = 0, nDef = 0, nNv = 0, nAl = 0, nSr = 0;
    wire sdaWire = sdaDrv & ~sdaOe; // Pulled up unless someone pulls low
    ctrl_port_reset_powerdown #(.NvWaitCycles(50)) dut (.sys_clk, .sys_rst,
        .sclIn, .sdaIn(sdaWire), .sdaOut(), .sdaOe, .port_sel_hi,
        .port_sel_lo, .nvSelect, .chip_sleep_n, .chargePumpEvent,
        .distClkLow, .spiEnable, .i2cEnable, .i2cAddress, .pllOff,
        .vcoOff, .dividerOff, .driverOff, .cmosTristate, .lvdsHiZ,
        .distPowerDown, .outputsStatic, .softResetActive, .loadDefaults,
        .nvReloadReq, .alignReq);
    i2c_host_model host (.scl(sclIn), .sdaDrv, .sdaWire);
    // System clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Tally single-cycle pulses and soft-reset cycles, sampled where they have settled
    always @(negedge sys_clk) begin
        nDef += int'(loadDefaults === 1'b1);
        nNv += int'(nvReloadReq === 1'b1);
        nAl += int'(alignReq === 1'b1);
        nSr += int'(softResetActive === 1'b1);
    end
    // Distribution clock phase, so the sleep gate must wait for it
    always @(negedge sys_clk) distClkLow <= ~distClkLow;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [6:0] expAddr(input int h, input int l);
        return {4'hB, 3'(h * 3 + l)};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rst();
        sys_rst = 1'b1;
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (12) @(negedge sys_clk);
    endtask
    // Whole write transfer; address ack is kept for the caller
    task automatic wr(input logic [6:0] a, input logic [15:0] r,
                      input logic [7:0] d);
        logic k;
        host.start();
        host.wbyte({a, 1'b0}, ack);
        host.wbyte(r[15:8], k);
        host.wbyte(r[7:0], k);
        host.wbyte(d, k);
        host.stop();
        repeat (12) @(negedge sys_clk);
    endtask
    task automatic rd(input logic [15:0] r);
        logic k;
        host.start();
        host.wbyte(8'hB0, k);
        host.wbyte(r[15:8], k);
        host.wbyte(r[7:0], k);
        host.start();
        host.wbyte(8'hB1, k);
        host.rbyte(1'b1, rdata);
        host.stop();
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog, well beyond the expected run
    initial begin
        #80us;
        fail_count++;
        wrap_up();
    end
    initial begin
        {sys_rst, nvSelect, chargePumpEvent, chip_sleep_n} = 4'h9;
        for (int h = 0; h < 3; h++) for (int l = 0; l < 3; l++) begin
            port_sel_hi = 2'(h);
            port_sel_lo = 2'(l);
            rst();
            chk({spiEnable, i2cEnable}, (h + l == 4) ? 2 : 1);
            if (h + l < 4) chk(i2cAddress, expAddr(h, l));
        end
        {port_sel_hi, port_sel_lo} = 4'h0;
        rst();
        seed = lfsr(seed);
        wr(7'h58, 16'h00F0, seed[7:0]);
        chk(ack, 1);
        chk(driverOff[0], seed[0]);
        rd(16'h00F0);
        chk(rdata, seed[0]);
        wr({4'h3, seed[10:8]}, 16'h00F0, 8'h00);
        chk({ack, driverOff[0]}, {1'b0, seed[0]});
        wr(7'h58, 16'h0230, 8'h02);
        chk({distPowerDown, driverOff}, 13'h1FFF);
        wr(7'h58, 16'h0230, 8'h00);
        wr(7'h58, 16'h0198, 8'h04);
        chk({dividerOff, driverOff[8:6]}, 7'h27);
        for (int m = 0; m < 4; m++) begin
            wr(7'h58, 16'h0010, 8'(m));
            if (m == 3) begin
                chk(pllOff, 0);
                chargePumpEvent = 1'b1;
                repeat (4) @(negedge sys_clk);
                chargePumpEvent = 1'b0;
                repeat (4) @(negedge sys_clk);
            end
            chk(pllOff, m % 2);
        end
        wr(7'h58, 16'h0000, 8'h34);
        chk(nDef, 1);
        chk({dividerOff, driverOff, pllOff}, 0);
        chk(nAl, 1);
        chk({softResetActive, nSr != 0}, 2'h1);
        rd(16'h0000);
        chk(rdata, 8'h10);
        nvSelect = 1'b1;
        wr(7'h58, 16'h0000, 8'h24);
        wr(7'h58, 16'h0B02, 8'h02);
        chk(nNv, 2);
        chk(outputsStatic, 1);
        repeat (50) @(negedge sys_clk);
        chk(outputsStatic, 0);
        nvSelect = 1'b0;
        wr(7'h58, 16'h0B02, 8'h02);
        chk(nNv + nDef, 3);
        chip_sleep_n = 1'b0;
        repeat (10) @(negedge sys_clk);
        chk({cmosTristate, lvdsHiZ, vcoOff, pllOff, dividerOff}, 8'hFF);
        wr(7'h58, 16'h00F1, 8'h01);
        chk(ack, 1);
        chip_sleep_n = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk({cmosTristate, driverOff[1:0]}, 3'h2);
        wrap_up();
    end
endmodule
